// ===== pll_core_clock_control.v
// PLL lock supervision, core clock division and the control register.
// Assumes the SFR bus and all pins are synchronous to CORE_CLK, which
// stands for the PLL output; XTAL_IN is the crystal clock level.
//
// Overview of operation
// - Crystal period is 512 PLL output cycles; lock checked against that ratio.
// - Core runs at full PLL rate or a binary submultiple of it.
// - After reset the core divider is 8, about 2.097152 MHz.
// - Converter tick at crystal rate, independent of the core divider.
// - Control register at D7H, reset 53H, byte access only.
// - Bit 7 stops the crystal oscillator in power-down when set.
// - Bit 6 is a read-only tracking flag, unaffected by writes.
// - No crystal at power-on clears the flag; PLL free-runs.
// - Crystal lost after lock rails the PLL and halts the core.
// - Bits 2:0 divide the core clock by two to that power.
// - Bit 3 runs interrupts at full speed, then back to divider.
// - External clock select swaps the PLL clock for a pin clock.
`timescale 1ns/1ns
`include "pll_clock_defines.vh"
module pll_core_clock_control #(
    parameter CNT_W = 11
) (
    input  wire       CORE_CLK,
    input  wire       NRST,
    input  wire [7:0] SFR_ADDR,
    input  wire [7:0] SFR_WDATA,
    input  wire       SFR_WR,
    input  wire       SFR_RD,
    output reg  [7:0] SFR_RDATA,
    output wire       SFR_HIT,
    input  wire       XTAL_IN,
    input  wire       POWER_DOWN,
    input  wire       IRQ_ACTIVE,
    input  wire       EXTERNAL_CLOCK_SELECT,
    input  wire       EXT_CLK_IN,
    output wire       XTAL_OSC_EN,
    output wire       CORE_TICK,
    output reg        MOD_TICK,
    output wire       PLL_LOCKED,
    output wire       CORE_HALT,
    output wire       CLK_SOURCE_EXT
);

    // ------------------------------------------------------------
    // Lock supervision states
    // ------------------------------------------------------------
    localparam ST_WAIT_EDGE = 4'b0001;
    localparam ST_MEASURE   = 4'b0010;
    localparam ST_TRACK     = 4'b0100;
    localparam ST_FREE      = 4'b1000;

    reg [3:0]       state;
    reg [CNT_W-1:0] period;
    reg             xtal_q;
    reg             lock_flag;
    reg             railed;
    reg             crystal_osc_powerdown;
    reg             fast_irq_clock_bit;
    reg [1:0]       rsvd;
    reg [2:0]       core_div;
    reg [8:0]       mod_count;
    reg             ext_q;
    reg [2:0]       eff_div;
    reg [7:0]       next_rdata;

    wire            pll_tick;
    wire            xtal_rise = XTAL_IN & ~xtal_q;
    wire            ext_rise  = EXT_CLK_IN & ~ext_q;
    wire            timed_out =
        (period >= (`XTAL_LOSS_LIMIT - 1));
    wire            in_window =
        (period >= (`PLL_MULT - 1 - `LOCK_TOLERANCE)) &&
        (period <= (`PLL_MULT - 1 + `LOCK_TOLERANCE));
    wire            reg_hit   = (SFR_ADDR == `PLL_CLOCK_CONTROL_ADDR);
    wire            reg_write = SFR_WR & reg_hit;
    wire [7:0]      reset_val = `PLL_CLOCK_CONTROL_RST;
    wire [2:0]      reset_div = reset_val[`CORE_DIV_HI_BIT:`CORE_DIV_LO_BIT];
    wire            rail_now  = (state == ST_TRACK) & timed_out;

    assign SFR_HIT        = reg_hit & (SFR_WR | SFR_RD);
    assign PLL_LOCKED     = lock_flag;
    assign CORE_HALT      = railed;
    assign CLK_SOURCE_EXT = EXTERNAL_CLOCK_SELECT;
    assign XTAL_OSC_EN    = ~(POWER_DOWN & crystal_osc_powerdown);

    // ------------------------------------------------------------
    // Crystal edge detection and period counting
    // ------------------------------------------------------------
    always @(posedge CORE_CLK) begin
        if (!NRST) begin
            // Seed from the pins so release shows no false edge
            xtal_q <= XTAL_IN;
            ext_q  <= EXT_CLK_IN;
            period <= {CNT_W{1'b0}};
        end else begin
            xtal_q <= XTAL_IN;
            ext_q  <= EXT_CLK_IN;
            if (xtal_rise)
                period <= {CNT_W{1'b0}};
            else if (!timed_out)
                period <= period + 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Lock supervision
    // ------------------------------------------------------------
    always @(posedge CORE_CLK) begin
        if (!NRST) begin
            state     <= ST_WAIT_EDGE;
            lock_flag <= 1'b1;
            railed    <= 1'b0;
        end else begin
            case (state)
                ST_WAIT_EDGE: begin
                    if (xtal_rise) begin
                        state <= ST_MEASURE;
                    end else if (timed_out) begin
                        lock_flag <= 1'b0;
                        state     <= ST_FREE;
                    end
                end
                ST_MEASURE: begin
                    if (xtal_rise && in_window) begin
                        state <= ST_TRACK;
                    end else if (xtal_rise || timed_out) begin
                        lock_flag <= 1'b0;
                        state     <= ST_FREE;
                    end
                end
                ST_TRACK: begin
                    if (timed_out)
                        railed <= 1'b1;
                end
                ST_FREE: begin
                    state <= ST_FREE;
                end
                default: begin
                    state <= ST_WAIT_EDGE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------
    always @(posedge CORE_CLK) begin
        if (!NRST) begin
            crystal_osc_powerdown <= reset_val[`OSC_POWERDOWN_BIT];
            rsvd                  <= reset_val[`RSVD_HI_BIT:`RSVD_LO_BIT];
            fast_irq_clock_bit    <= reset_val[`FAST_IRQ_BIT];
            core_div              <= reset_div;
        end else if (reg_write) begin
            // Lock bit is never written
            crystal_osc_powerdown <= SFR_WDATA[`OSC_POWERDOWN_BIT];
            rsvd <= SFR_WDATA[`RSVD_HI_BIT:`RSVD_LO_BIT];
            fast_irq_clock_bit <= SFR_WDATA[`FAST_IRQ_BIT];
            core_div <= SFR_WDATA[`CORE_DIV_HI_BIT:`CORE_DIV_LO_BIT];
        end
    end

    // ------------------------------------------------------------
    // Register read path
    // ------------------------------------------------------------
    always @* begin
        next_rdata = 8'h00;
        if (reg_hit && SFR_RD)
            next_rdata = {crystal_osc_powerdown, lock_flag, rsvd,
                          fast_irq_clock_bit, core_div};
    end

    always @(posedge CORE_CLK) begin
        if (!NRST)
            SFR_RDATA <= 8'h00;
        else
            SFR_RDATA <= next_rdata;
    end

    // ------------------------------------------------------------
    // Core clock selection
    // ------------------------------------------------------------
    always @* begin
        eff_div = core_div;
        if (fast_irq_clock_bit && IRQ_ACTIVE)
            eff_div = 3'h0;
    end

    core_clock_gen #(
        .DIV_W     (3),
        .CNT_W     (7)
    ) core_clock_gen_i (
        .clk       (CORE_CLK),
        .rst_n     (NRST),
        .run       (~railed),
        .div       (eff_div),
        .reset_div (reset_div),
        .tick      (pll_tick)
    );

    // ------------------------------------------------------------
    // Core tick output
    // ------------------------------------------------------------
    assign CORE_TICK = railed ? 1'b0 :
                       (EXTERNAL_CLOCK_SELECT ? ext_rise : pll_tick);

    // ------------------------------------------------------------
    // Converter tick at the crystal rate
    // ------------------------------------------------------------
    always @(posedge CORE_CLK) begin
        if (!NRST) begin
            mod_count <= 9'h000;
            MOD_TICK  <= 1'b0;
        end else if (railed) begin
            MOD_TICK <= 1'b0;
        end else begin
            mod_count <= mod_count + 1'b1;
            // Crystal loss stops the converter tick at once
            MOD_TICK  <= (mod_count == 9'h1ff) & ~rail_now;
        end
    end

endmodule // pll_core_clock_control

// ===== pll_clock_defines.vh
// Constants for the PLL and core clock control block.
// Included by the design files; holds definitions only.
`ifndef PLL_CLOCK_DEFINES_VH
`define PLL_CLOCK_DEFINES_VH

// Register address and reset value
`define PLL_CLOCK_CONTROL_ADDR 8'hd7
`define PLL_CLOCK_CONTROL_RST  8'h53

// Field positions
`define OSC_POWERDOWN_BIT 7
`define LOCK_BIT          6
`define RSVD_HI_BIT       5
`define RSVD_LO_BIT       4
`define FAST_IRQ_BIT      3
`define CORE_DIV_HI_BIT   2
`define CORE_DIV_LO_BIT   0

// Timing counts in PLL clock cycles
`define PLL_MULT        512
`define LOCK_TOLERANCE  8
`define XTAL_LOSS_LIMIT 1024

`endif

// ===== core_clock_gen.v
// Core clock pulse generator: one pulse every 2**div input cycles.
// Assumes a synchronous active-low reset and a stable divider input.
`timescale 1ns/1ns
module core_clock_gen #(
    parameter DIV_W = 3,
    parameter CNT_W = 7
) (
    input  wire             clk,
    input  wire             rst_n,
    input  wire             run,
    input  wire [DIV_W-1:0] div,
    input  wire [DIV_W-1:0] reset_div,
    output reg              tick
);

    reg [CNT_W-1:0] count;
    reg [DIV_W-1:0] active_div;

    function [CNT_W-1:0] last_count;
        input [DIV_W-1:0] d;
        begin
            last_count = (({{(CNT_W-1){1'b0}}, 1'b1}) << d) - 1'b1;
        end
    endfunction

    // ------------------------------------------------------------
    // Divider: new setting taken only at a period boundary
    // ------------------------------------------------------------
    always @(posedge clk) begin
        if (!rst_n) begin
            count      <= {CNT_W{1'b0}};
            active_div <= reset_div;
            tick       <= 1'b0;
        end else if (!run) begin
            tick <= 1'b0;
        end else if (count >= last_count(active_div)) begin
            count      <= {CNT_W{1'b0}};
            active_div <= div;
            tick       <= 1'b1;
        end else begin
            count <= count + 1'b1;
            tick  <= 1'b0;
        end
    end

endmodule // core_clock_gen

// ===== xtal_model.sv
// Watch crystal model: square wave, HALF_CYC core cycles per half.
// Assumes clk stands for the PLL output; run low stops the crystal.
`timescale 1ns/1ns
module xtal_model #(parameter HALF_CYC = 256) (
    input  wire clk,
    input  wire run,
    output reg  xtal
);
    reg [8:0] n = 9'h000;
    initial xtal = 1'b0;
    always @(posedge clk) begin
        n <= (run && n < HALF_CYC - 1) ? n + 9'h001 : 9'h000;
        if (run && n == HALF_CYC - 1) xtal <= ~xtal;
    end
endmodule // xtal_model

// ===== pll_clock_sva.sv
// Checker for the PLL clock control block, bound to its top ports.
// Assumes one clock, CORE_CLK, and a synchronous active-low NRST.
`timescale 1ns/1ns
module pll_clock_sva (
    input wire       CORE_CLK,
    input wire       NRST,
    input wire [7:0] SFR_ADDR,
    input wire       SFR_RD,
    input wire [7:0] SFR_RDATA,
    input wire       SFR_HIT,
    input wire       POWER_DOWN,
    input wire       EXTERNAL_CLOCK_SELECT,
    input wire       EXT_CLK_IN,
    input wire       XTAL_OSC_EN,
    input wire       CORE_TICK,
    input wire       MOD_TICK,
    input wire       PLL_LOCKED,
    input wire       CORE_HALT,
    input wire       CLK_SOURCE_EXT
);
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!NRST);
    addr_decode_a: assert property (
        SFR_ADDR != 8'hd7 |-> !SFR_HIT) else $error("hit off address");
    rdata_idle_a: assert property (
        !(SFR_RD && SFR_ADDR == 8'hd7) |=> SFR_RDATA == 8'h00)
        else $error("read data not cleared");
    lock_read_a: assert property (
        SFR_RD && SFR_ADDR == 8'hd7 |=> SFR_RDATA[6] == $past(PLL_LOCKED))
        else $error("lock bit read wrong");
    reset_div_a: assert property (
        $rose(NRST) && !CLK_SOURCE_EXT |-> !CORE_TICK[*4] ##[1:6] CORE_TICK)
        else $error("first core tick late");
    mod_space_a: assert property (
        MOD_TICK |=> !MOD_TICK[*8]) else $error("converter tick too close");
    osc_run_a: assert property (
        !POWER_DOWN |-> XTAL_OSC_EN) else $error("oscillator off in run");
    halt_stop_a: assert property (
        CORE_HALT |-> !CORE_TICK && !MOD_TICK) else $error("ticks in halt");
    halt_sticky_a: assert property (
        CORE_HALT |=> CORE_HALT) else $error("halt released");
    ext_select_a: assert property (
        EXTERNAL_CLOCK_SELECT |-> CLK_SOURCE_EXT) else $error("no ext source");
    ext_tick_a: assert property (
        EXTERNAL_CLOCK_SELECT && !CORE_HALT |->
        CORE_TICK == (EXT_CLK_IN && !$past(EXT_CLK_IN)))
        else $error("ext tick wrong");
    cover property (MOD_TICK);
    cover property (CLK_SOURCE_EXT && CORE_TICK);
    cover property ($rose(CORE_HALT));
    cover property (SFR_RD && SFR_ADDR == 8'hd7);
endmodule // pll_clock_sva
bind pll_core_clock_control pll_clock_sva pll_clock_sva_i (
    .CORE_CLK(CORE_CLK), .NRST(NRST), .SFR_ADDR(SFR_ADDR), .SFR_RD(SFR_RD),
    .SFR_RDATA(SFR_RDATA), .SFR_HIT(SFR_HIT), .POWER_DOWN(POWER_DOWN),
    .EXTERNAL_CLOCK_SELECT(EXTERNAL_CLOCK_SELECT), .XTAL_OSC_EN(XTAL_OSC_EN),
    .EXT_CLK_IN(EXT_CLK_IN),
    .CORE_TICK(CORE_TICK), .MOD_TICK(MOD_TICK), .PLL_LOCKED(PLL_LOCKED),
    .CORE_HALT(CORE_HALT), .CLK_SOURCE_EXT(CLK_SOURCE_EXT));

// ===== pll_core_clock_control_tb_top.sv
// Self-checking bench for the PLL clock control block.
// Assumes the crystal model and the bound checker are compiled first.
`timescale 1ns/1ns
module pll_core_clock_control_tb_top;
    reg        clk = 1'b0, nrst = 1'b0, wr = 1'b0, rd = 1'b0, rd_d = 1'b0;
    reg  [7:0] addr = 8'h00, wdata = 8'h00, r, gap = 8'h00;
    reg        pd = 1'b0, irq = 1'b0, esel = 1'b0, eclk = 1'b0, run = 1'b1;
    reg  [9:0] mgap = 10'h000;
    reg        mseen = 1'b0;
    wire [7:0] rdata;
    wire       hit, xtal, osc_en, tick, mtick, locked, halt, src_ext;
    reg  [7:0] rq[$], pq[$];
    integer    failures = 0, samples_checked = 0, i;
    always #50 clk = ~clk;
    xtal_model xtal_model_i (.clk(clk), .run(run & osc_en), .xtal(xtal));
    pll_core_clock_control pll_core_clock_control_i (
        .CORE_CLK(clk), .NRST(nrst), .SFR_ADDR(addr), .SFR_WDATA(wdata),
        .SFR_WR(wr), .SFR_RD(rd), .SFR_RDATA(rdata), .SFR_HIT(hit),
        .XTAL_IN(xtal), .POWER_DOWN(pd), .IRQ_ACTIVE(irq),
        .EXTERNAL_CLOCK_SELECT(esel), .EXT_CLK_IN(eclk),
        .XTAL_OSC_EN(osc_en), .CORE_TICK(tick), .MOD_TICK(mtick),
        .PLL_LOCKED(locked), .CORE_HALT(halt), .CLK_SOURCE_EXT(src_ext));
    task check(input [7:0] got, input [7:0] exp);
        begin
            samples_checked = samples_checked + 1;
            if (got !== exp) begin
                failures = failures + 1;
                $display("[FAIL] %0t got %h want %h", $time, got, exp);
            end
        end
    endtask
    task report_and_stop;
        begin
            $display("checked %0d failures %0d", samples_checked, failures);
            if (failures == 0 && samples_checked > 0)
                $display("No errors found");
            else
                $display("Errors were found");
            $finish;
        end
    endtask
    task sfr_write(input [7:0] a, input [7:0] d);
        begin
            @(negedge clk) addr = a;
            wdata = d;
            wr = 1'b1;
            @(negedge clk) wr = 1'b0;
        end
    endtask
    task sfr_read(input [7:0] a, input [7:0] exp);
        begin
            @(negedge clk) addr = a;
            rd = 1'b1;
            rq.push_back(exp);
            @(negedge clk) rd = 1'b0;
        end
    endtask
    task period(input [7:0] exp);
        begin
            repeat (3) @(negedge clk iff tick);
            pq.push_back(exp);
        end
    endtask
    // Monitor: read data, core tick gaps, converter tick gaps
    always @(posedge clk) rd_d <= rd;
    always @(negedge clk) begin
        gap = gap + 8'h01;
        if (tick) begin
            if (pq.size() > 0) check(gap, pq.pop_front());
            gap = 8'h00;
        end
    end
    always @(negedge clk) begin
        mgap = mgap + 10'h001;
        if (!nrst) begin
            mseen = 1'b0;
        end else if (mtick) begin
            if (mseen) check(mgap == 10'h200, 1'b1);
            mseen = 1'b1;
            mgap  = 10'h000;
        end
    end
    always @(negedge clk) if (rd_d) check(rdata, rq.pop_front());
    initial begin
        #3000000;
        failures = failures + 1;
        report_and_stop;
    end
    initial begin
        i = $urandom(66);
        repeat (6) @(negedge clk);
        nrst = 1'b1;
        sfr_read(8'hd7, 8'h53);
        period(8'h08);
        for (i = 0; i < 8; i = i + 1) begin
            sfr_write(8'hd7, i[7:0]);
            period(8'h01 << i);
        end
        sfr_write(8'hd7, 8'h0f);
        irq = 1'b1;
        period(8'h01);
        irq = 1'b0;
        period(8'h80);
        repeat (1200) @(negedge clk);
        repeat (4) begin
            r = $urandom & 8'h8f;
            sfr_write(8'hd7, r);
            sfr_read(8'hd7, r | 8'h40);
        end
        sfr_write(8'hd6, 8'hff);
        sfr_read(8'hd6, 8'h00);
        sfr_read(8'hd7, r | 8'h40);
        sfr_write(8'hd7, 8'h83);
        pd = 1'b1;
        @(negedge clk) check(osc_en, 8'h00);
        sfr_write(8'hd7, 8'h03);
        check(osc_en, 8'h01);
        pd = 1'b0;
        esel = 1'b1;
        repeat (4) begin
            @(negedge clk) eclk = ~eclk;
            #10 check(tick, eclk);
        end
        check(locked, 8'h01);
        esel = 1'b0;
        run = 1'b0;
        repeat (1100) @(negedge clk);
        check(halt, 8'h01);
        nrst = 1'b0;
        repeat (6) @(negedge clk);
        nrst = 1'b1;
        repeat (1300) @(negedge clk);
        sfr_read(8'hd7, 8'h13);
        check(halt, 8'h00);
        check(locked, 8'h00);
        report_and_stop;
    end
endmodule // pll_core_clock_control_tb_top
